// *** verilog/level_trigger_detector.v ***
// channel level trigger detector with apb register access
// Overview of operation
// [RL1] software must set channel bit in or mask
// [RL2] every sample evaluated, no gaps
// [RL3] code 1h: trigger on rising level crossing
// [RL4] code 2h: trigger on falling level crossing
// [RL5] code 4h: trigger on either crossing
// [RL6] rising re-arm: arm via aux, fire primary
// [RL7] re-arm: disarm on trigger until rearmed
// [RL8] falling re-arm: primary arms, aux fires
// [RL9] window entry: outside to inside fires
// [RL10] window exit: inside to outside fires
// [RL11] re-arm is an or-ed flag bit; code also names falling re-arm 00100002h, which lacks it
// [RL12] levels clamped to -32767..+32767
// [RL13] crossing from sample pair, one-cycle pulse
// [RL14] masked-off channel never triggers
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "trig_map.vh"
module level_trigger_detector (
   input  wire        clk,
   input  wire        rst,
   input  wire        ce,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [17:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire [15:0] sample_data,
   input  wire        sample_valid,
   output reg         trig_out,
   output reg         irq
);

   // register state
   reg  [31:0] or_mask_ff;
   reg  [31:0] mode_ff;
   reg  [15:0] lvl_pri_ff;
   reg  [15:0] lvl_aux_ff;
   reg  [1:0]  irq_status_ff;
   reg  [1:0]  irq_mask_ff;

   // detector state
   reg  [15:0] prev_ff;
   reg         primed_ff;
   reg         armed_ff;
   reg  [15:0] trig_cnt_ff;

   // next values
   reg  [31:0] nxt_prdata;
   reg         nxt_pslverr;
   reg         nxt_armed;
   reg         fire;
   reg         arm_evt;
   reg  [15:0] nxt_level;

   wire        bus_req;
   wire        bus_done;
   wire        wr_en;
   wire        sel_or_mask;
   wire        sel_mode;
   wire        sel_pri;
   wire        sel_aux;
   wire        sel_status;
   wire        sel_mask;
   wire        sel_state;
   wire        sel_any;
   wire        eval;
   wire        ch_enabled;

   wire        pri_rise;
   wire        pri_fall;
   wire        pri_cur_above;
   wire        pri_cur_below;
   wire        pri_prev_above;
   wire        pri_prev_below;
   wire        aux_rise;
   wire        aux_fall;
   wire        aux_cur_above;
   wire        aux_cur_below;
   wire        aux_prev_above;
   wire        aux_prev_below;
   wire        inside_cur;
   wire        inside_prev;
   wire        is_rearm;
   wire [1:0]  irq_set;
   wire [1:0]  irq_clr;
   wire [31:0] state_word;

   // apb decode; one wait state, answer registered
   assign bus_req     = psel && penable && !pready;
   assign bus_done    = psel && penable && pready;
   assign wr_en       = bus_done && pwrite;
   assign sel_or_mask = paddr == {`IDX_OR_MASK, 2'b00};
   assign sel_mode    = paddr == {`IDX_MODE, 2'b00};
   assign sel_pri     = paddr == {`IDX_LVL_PRIMARY, 2'b00};
   assign sel_aux     = paddr == {`IDX_LVL_AUX, 2'b00};
   assign sel_status  = paddr == {`IDX_IRQ_STATUS, 2'b00};
   assign sel_mask    = paddr == {`IDX_IRQ_MASK, 2'b00};
   assign sel_state   = paddr == {`IDX_CHAN_STATE, 2'b00};
   assign sel_any     = sel_or_mask || sel_mode || sel_pri || sel_aux ||
                        sel_status || sel_mask || sel_state;

   assign state_word  = {trig_cnt_ff, 14'h0000, primed_ff, armed_ff};

   always @* begin
      nxt_pslverr = !sel_any;
      case (1'b1)
         sel_or_mask: nxt_prdata = or_mask_ff;
         sel_mode:    nxt_prdata = mode_ff;
         sel_pri:     nxt_prdata = {{16{lvl_pri_ff[15]}}, lvl_pri_ff};
         sel_aux:     nxt_prdata = {{16{lvl_aux_ff[15]}}, lvl_aux_ff};
         sel_status:  nxt_prdata = {30'h00000000, irq_status_ff};
         sel_mask:    nxt_prdata = {30'h00000000, irq_mask_ff};
         sel_state:   nxt_prdata = state_word;
         default:     nxt_prdata = `RST_WORD;
      endcase
   end

   // out-of-range levels saturate instead of wrapping
   always @* begin
      if ($signed(pwdata) > `LVL_MAX) begin
         nxt_level = `LVL_MAX16; // [RL12]
      end else if ($signed(pwdata) < `LVL_MIN) begin
         nxt_level = `LVL_MIN16; // [RL12]
      end else begin
         nxt_level = pwdata[15:0];
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= `RST_WORD;
      end else if (ce) begin
         pready  <= bus_req;
         pslverr <= bus_req && nxt_pslverr;
         if (bus_req) begin
            prdata <= pwrite ? `RST_WORD : nxt_prdata;
         end else begin
            prdata <= `RST_WORD;
         end
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         or_mask_ff  <= `RST_WORD;
         mode_ff     <= `RST_WORD;
         lvl_pri_ff  <= `RST_LEVEL;
         lvl_aux_ff  <= `RST_LEVEL;
         irq_mask_ff <= 2'b00;
      end else if (ce && wr_en) begin
         if (sel_or_mask) begin
            or_mask_ff <= pwdata;
         end
         if (sel_mode) begin
            mode_ff <= pwdata;
         end
         if (sel_pri) begin
            lvl_pri_ff <= nxt_level;
         end
         if (sel_aux) begin
            lvl_aux_ff <= nxt_level;
         end
         if (sel_mask) begin
            irq_mask_ff <= pwdata[1:0];
         end
      end
   end

   // comparators for both levels
   edge_compare u_cmp_pri (
      .cur        (sample_data),
      .prev       (prev_ff),
      .level      (lvl_pri_ff),
      .rise       (pri_rise),
      .fall       (pri_fall),
      .cur_above  (pri_cur_above),
      .cur_below  (pri_cur_below),
      .prev_above (pri_prev_above),
      .prev_below (pri_prev_below)
   );

   edge_compare u_cmp_aux (
      .cur        (sample_data),
      .prev       (prev_ff),
      .level      (lvl_aux_ff),
      .rise       (aux_rise),
      .fall       (aux_fall),
      .cur_above  (aux_cur_above),
      .cur_below  (aux_cur_below),
      .prev_above (aux_prev_above),
      .prev_below (aux_prev_below)
   );

   // window: primary is the upper bound, auxiliary the lower
   assign inside_cur  = !pri_cur_above && !aux_cur_below;
   assign inside_prev = !pri_prev_above && !aux_prev_below;

   // a crossing needs a previous sample, so the first one only primes
   assign eval       = sample_valid && primed_ff; // [RL2]
   assign ch_enabled = or_mask_ff[`OR_BIT_FIRST_CH]; // [RL1]
   // the falling re-arm code carries no flag bit, so it is named here too
   assign is_rearm   = ((mode_ff & `REARM_FLAG) != `RST_WORD) ||
                       (mode_ff == `MODE_FALL_REARM); // [RL11]

   always @* begin
      fire    = 1'b0;
      arm_evt = 1'b0;
      case (mode_ff)
         `MODE_RISING: begin
            fire = pri_rise; // [RL3]
         end
         `MODE_FALLING: begin
            fire = pri_fall; // [RL4]
         end
         `MODE_DUAL: begin
            fire = pri_rise || pri_fall; // [RL5]
         end
         `MODE_RISE_REARM: begin
            arm_evt = aux_rise; // [RL6]
            fire    = armed_ff && pri_rise; // [RL6]
         end
         `MODE_FALL_REARM, (`MODE_FALLING | `REARM_FLAG): begin
            arm_evt = pri_fall; // [RL8]
            fire    = armed_ff && aux_fall; // [RL8]
         end
         `MODE_WIN_ENTRY: begin
            fire = inside_cur && !inside_prev; // [RL9]
         end
         `MODE_WIN_EXIT: begin
            fire = !inside_cur && inside_prev; // [RL10]
         end
         default: begin
            fire = 1'b0;
         end
      endcase
      if (!eval) begin
         fire    = 1'b0;
         arm_evt = 1'b0;
      end
   end

   // a trigger disarms even if the same sample would arm again
   always @* begin
      if (fire && is_rearm) begin
         nxt_armed = 1'b0; // [RL7]
      end else if (arm_evt && !armed_ff) begin
         nxt_armed = 1'b1;
      end else begin
         nxt_armed = armed_ff;
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         prev_ff     <= `RST_LEVEL;
         primed_ff   <= 1'b0;
         armed_ff    <= 1'b0;
         trig_out    <= 1'b0;
         trig_cnt_ff <= 16'h0000;
      end else if (ce) begin
         if (sample_valid) begin
            prev_ff   <= sample_data; // [RL13]
            primed_ff <= 1'b1;
         end
         // a new mode starts disarmed
         if (wr_en && sel_mode) begin
            armed_ff <= 1'b0; // [RL7]
         end else begin
            armed_ff <= nxt_armed;
         end
         trig_out <= fire && ch_enabled; // [RL14]
         if (fire && ch_enabled) begin
            trig_cnt_ff <= trig_cnt_ff + 16'h0001;
         end
      end
   end

   // sticky events; a set in the clearing cycle wins
   assign irq_set = {arm_evt && !armed_ff, fire && ch_enabled};
   assign irq_clr = (wr_en && sel_status) ? pwdata[1:0] : 2'b00;

   always @(posedge clk) begin
      if (rst) begin
         irq_status_ff <= 2'b00;
         irq <= 1'b0;
      end else if (ce) begin
         irq_status_ff <= (irq_status_ff & ~irq_clr) | irq_set;
         irq <= |(((irq_status_ff & ~irq_clr) | irq_set) & irq_mask_ff);
      end
   end

endmodule
`default_nettype wire

// *** common/trig_map.vh ***
// register map, mode codes and field constants of the level trigger detector
`ifndef TRIG_MAP_VH
`define TRIG_MAP_VH

// register indices; byte address is four times the index
`define IDX_OR_MASK      16'h9e0c
`define IDX_MODE         16'h9ea2
`define IDX_LVL_PRIMARY  16'ha4d8
`define IDX_LVL_AUX      16'ha53c
`define IDX_IRQ_STATUS   16'ha600
`define IDX_IRQ_MASK     16'ha601
`define IDX_CHAN_STATE   16'ha602

// mode codes
`define MODE_RISING      32'h00000001
`define MODE_FALLING     32'h00000002
`define MODE_DUAL        32'h00000004
`define MODE_WIN_ENTRY   32'h00000020
`define MODE_WIN_EXIT    32'h00000040
`define REARM_FLAG       32'h01000000
`define MODE_RISE_REARM  32'h01000001
`define MODE_FALL_REARM  32'h00100002

// level limits and field positions
`define LVL_MAX          32'sh00007fff
`define LVL_MIN          32'shffff8001
`define LVL_MAX16        16'h7fff
`define LVL_MIN16        16'h8001
`define OR_BIT_FIRST_CH  0
`define IRQ_BIT_TRIG     0
`define IRQ_BIT_ARM      1
`define STATE_BIT_ARMED  0
`define STATE_BIT_PRIMED 1
`define STATE_CNT_LSB    16
`define RST_WORD         32'h00000000
`define RST_LEVEL        16'h0000

`endif

// *** verilog/edge_compare.v ***
// compares one sample pair against one signed level
`timescale 1ns/10ps
`default_nettype none
module edge_compare (
   input  wire [15:0] cur,
   input  wire [15:0] prev,
   input  wire [15:0] level,
   output wire        rise,
   output wire        fall,
   output wire        cur_above,
   output wire        cur_below,
   output wire        prev_above,
   output wire        prev_below
);
   assign cur_above  = $signed(cur) > $signed(level);
   assign cur_below  = $signed(cur) < $signed(level);
   assign prev_above = $signed(prev) > $signed(level);
   assign prev_below = $signed(prev) < $signed(level);
   // crossing judged from previous sample to current one
   assign rise       = !prev_above && cur_above; // [RL13]
   assign fall       = !prev_below && cur_below; // [RL13]
endmodule
`default_nettype wire

// *** tb/sample_source.sv ***
// adc sample stream model for the trigger detector bench
`timescale 1ns/10ps
`default_nettype none
module sample_source (
   input  wire logic        clk,
   output var  logic [15:0] sample_data,
   output var  logic        sample_valid
);
   initial {sample_data, sample_valid} = 17'h0;
   // idle lines toggle so a stale sample never looks valid
   task automatic idle();
      @(posedge clk);
      {sample_data, sample_valid} <= {~sample_data, 1'b0};
   endtask
   // gap idle cycles model a slow converter
   task automatic put(input logic [15:0] val, input int gap);
      repeat (gap) idle();
      @(posedge clk);
      {sample_data, sample_valid} <= {val, 1'b1};
   endtask
endmodule
`default_nettype wire

// *** tb/trig_monitor.sv ***
// port checker for the level trigger detector
`timescale 1ns/10ps
`default_nettype none
`include "trig_map.vh"
module trig_monitor (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        ce,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [17:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [15:0] sample_data,
   input wire logic        sample_valid,
   input wire logic        trig_out
);
   logic [31:0]        md_ff, om_ff;
   logic signed [15:0] lp_ff, pv_ff;
   logic               pr_ff;
   wire logic          wr = psel && penable && pready && pwrite && ce;
   wire logic          sv = sample_valid && ce;
   // shadow takes levels unsaturated, so only in-range writes are trusted
   always_ff @(posedge clk) begin
      if (rst) begin
         {md_ff, om_ff, lp_ff, pv_ff, pr_ff} <= '0;
      end else begin
         if (wr && paddr == {`IDX_MODE, 2'b00}) md_ff <= pwdata;
         if (wr && paddr == {`IDX_OR_MASK, 2'b00}) om_ff <= pwdata;
         if (wr && paddr == {`IDX_LVL_PRIMARY, 2'b00}) lp_ff <= pwdata[15:0];
         if (sv) {pv_ff, pr_ff} <= {sample_data, 1'b1};
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_rdy_once; pready |=> !pready; endproperty
   a_rdy_once: assert property (p_rdy_once) else $error("ready too long");
   property p_rdy_wait; psel && penable && !pready && ce |=> pready; endproperty
   a_rdy_wait: assert property (p_rdy_wait) else $error("ready late");
   property p_err_rdy; pslverr |-> pready; endproperty
   a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
   property p_rd_idle; !pready |-> prdata == 32'h0; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
   property p_trig_src; trig_out |-> $past(sv); endproperty
   a_trig_src: assert property (p_trig_src) else $error("trigger without sample");
   property p_mask_off; !om_ff[0] |=> !trig_out; endproperty
   a_mask_off: assert property (p_mask_off) else $error("masked channel fired");
   property p_rise; md_ff == `MODE_RISING && om_ff[0] && pr_ff && sv && pv_ff <= lp_ff
      && $signed(sample_data) > lp_ff |=> trig_out; endproperty
   a_rise: assert property (p_rise) else $error("rise missed");
   property p_fall; md_ff == `MODE_FALLING && om_ff[0] && pr_ff && sv && pv_ff >= lp_ff
      && $signed(sample_data) < lp_ff |=> trig_out; endproperty
   a_fall: assert property (p_fall) else $error("fall missed");
endmodule
bind level_trigger_detector trig_monitor trig_monitor_inst (.clk(clk), .rst(rst), .ce(ce),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_data(sample_data),
   .sample_valid(sample_valid), .trig_out(trig_out));
`default_nettype wire

// *** tb/channel_level_trigger_detector_bench.sv ***
// self-checking bench for the channel level trigger detector
`timescale 1ns/10ps
`default_nettype none
`include "trig_map.vh"
module channel_level_trigger_detector_bench;
   logic               clk, rst, psel, penable, pwrite, pready, pslverr, trig_out, irq;
   logic               sample_valid, vd, armed, primed, ce;
   logic [17:0]        paddr;
   logic [31:0]        pwdata, prdata, md, om;
   logic [15:0]        sample_data;
   logic signed [15:0] lp, la, pv;
   logic [33:0]        rq[$], e;
   logic               tq[$];
   int                 mismatches, tests_run, seed;
   logic [31:0]        modes[10] = '{32'h1, 32'h2, 32'h4, 32'h20, 32'h40, 32'h01000001,
                                     32'h01000002, 32'h00100002, 32'h4, 32'h8};
   logic [15:0]        regs[7] = '{`IDX_OR_MASK, `IDX_MODE, `IDX_LVL_PRIMARY, `IDX_LVL_AUX,
                                   `IDX_IRQ_STATUS, `IDX_IRQ_MASK, `IDX_CHAN_STATE};
   level_trigger_detector level_trigger_detector_inst (.clk(clk), .rst(rst), .ce(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_data(sample_data),
      .sample_valid(sample_valid), .trig_out(trig_out), .irq(irq));
   sample_source sample_source_inst (.clk(clk), .sample_data(sample_data),
      .sample_valid(sample_valid));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("mismatches %0d tests_run %0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d, exp,
                      input logic err);
      int n;
      @(posedge clk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, idx, 2'b00, d};
      rq.push_back({w, err, exp});
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (!pready && n < 20);
      {psel, penable} <= 2'b00;
      if (!pready) begin
         mismatches++;
         stop_test();
      end
   endtask
   task automatic wr(input logic [15:0] idx, input logic [31:0] d);
      case (idx)
         `IDX_MODE: {md, armed} = {d, 1'b0};
         `IDX_OR_MASK: om = d;
         `IDX_LVL_PRIMARY: lp = d[15:0];
         `IDX_LVL_AUX: la = d[15:0];
         default: ;
      endcase
      apb(1'b1, idx, d, 32'h0, 1'b0);
   endtask
   task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0, exp, 1'b0);
   endtask
   // only a real trigger disarms; an unarmed engine may arm on any sample
   function automatic logic ref_fire(input logic signed [15:0] c);
      logic f, up, dn, ua, da, ip, ic;
      if (!primed) begin
         {primed, pv} = {1'b1, c};
         return 1'b0;
      end
      up = pv <= lp && c > lp;
      dn = pv >= lp && c < lp;
      ua = pv <= la && c > la;
      da = pv >= la && c < la;
      ip = pv >= la && pv <= lp;
      ic = c >= la && c <= lp;
      case (md)
         `MODE_RISING: f = up;
         `MODE_FALLING: f = dn;
         `MODE_DUAL: f = up || dn;
         `MODE_WIN_ENTRY: f = !ip && ic;
         `MODE_WIN_EXIT: f = ip && !ic;
         `MODE_RISE_REARM: begin
            f = armed && up;
            armed = f ? 1'b0 : (armed || ua);
         end
         `MODE_FALL_REARM, `REARM_FLAG | `MODE_FALLING: begin
            f = armed && da;
            armed = f ? 1'b0 : (armed || dn);
         end
         default: f = 1'b0;
      endcase
      pv = c;
      return f && om[0];
   endfunction
   task automatic smp(input logic [15:0] c, input int gap);
      tq.push_back(ref_fire(c));
      sample_source_inst.put(c, gap);
   endtask
   always @(posedge clk) begin
      vd <= sample_valid && ce;
      if (vd)
         check(trig_out, tq.size() > 0 ? tq.pop_front() : 1'bx);
      if (psel && penable && pready) begin
         e = rq.pop_front();
         check(pslverr, e[32]);
         if (!e[33])
            check(prdata, e[31:0]);
      end
   end
   initial begin
      seed = 32'haa1aee44;
      {rst, psel, penable, pwrite, paddr, pwdata, vd} = {1'b1, 54'h0};
      {md, om, lp, la, pv, armed, primed} = '0;
      {mismatches, tests_run} = '0;
      ce = 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      foreach (regs[i])
         rd(regs[i], 32'h0);
      apb(1'b1, 16'h0001, 32'hffffffff, 32'h0, 1'b1);
      apb(1'b0, 16'h0001, 32'h0, 32'h0, 1'b1);
      wr(`IDX_LVL_PRIMARY, 32'h00008000);
      rd(`IDX_LVL_PRIMARY, 32'h00007fff);
      wr(`IDX_LVL_AUX, 32'hffff8000);
      rd(`IDX_LVL_AUX, 32'hffff8001);
      wr(`IDX_IRQ_MASK, 32'h1);
      wr(`IDX_LVL_PRIMARY, 32'h64);
      wr(`IDX_MODE, 32'h1);
      wr(`IDX_OR_MASK, 32'h1);
      smp(16'h0032, 0);
      smp(16'h0096, 0);
      sample_source_inst.idle();
      repeat (3) @(posedge clk);
      check(irq, 1'b1);
      // a sample taken while frozen must not become the previous sample
      ce <= 1'b0;
      sample_source_inst.put(16'h0032, 0);
      sample_source_inst.idle();
      ce <= 1'b1;
      smp(16'h0096, 0);
      sample_source_inst.idle();
      repeat (2) @(posedge clk);
      rd(`IDX_IRQ_STATUS, 32'h1);
      wr(`IDX_IRQ_STATUS, 32'h1);
      repeat (2) @(posedge clk);
      check(irq, 1'b0);
      wr(`IDX_IRQ_MASK, 32'h0);
      for (int i = 0; i < 10; i++) begin
         wr(`IDX_LVL_PRIMARY, {$random(seed)} % 100);
         wr(`IDX_LVL_AUX, -({$random(seed)} % 100));
         wr(`IDX_OR_MASK, i != 8);
         wr(`IDX_MODE, modes[i]);
         repeat (40)
            smp($random(seed) % 300, $random(seed) & 3);
         sample_source_inst.idle();
      end
      check(irq, 1'b0);
      stop_test();
   end
endmodule
`default_nettype wire
